// ===== core/ebcc_pkg.sv
// Constants, types and helpers for the external bus cycle configuration block
package ebcc_pkg;
	// Timing base: one half-period of the CPU clock, rounded up to whole cycles
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TCL_NS        = 5;
	localparam int unsigned TCL_CYC       = (TCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Phase lengths in half-periods, then in cycles
	localparam int unsigned ALE_TCL      = 1;
	localparam int unsigned ALE_LONG_TCL = 2;
	localparam int unsigned DELAY_TCL    = 1;
	localparam int unsigned CMD_TCL      = 2;
	localparam int unsigned WAIT_TCL     = 2;
	localparam logic [5:0]  ALE_CYC      = 6'(ALE_TCL * TCL_CYC);
	localparam logic [5:0]  ALE_LONG_CYC = 6'(ALE_LONG_TCL * TCL_CYC);
	localparam logic [5:0]  DELAY_CYC    = 6'(DELAY_TCL * TCL_CYC);
	localparam logic [5:0]  CMD_CYC      = 6'(CMD_TCL * TCL_CYC);
	localparam logic [5:0]  WAIT_CYC     = 6'(WAIT_TCL * TCL_CYC);
	localparam logic [3:0]  MAX_WAIT     = 4'hf;
	// Register indices; byte address is four times the index
	localparam logic [15:0] CFG_IDX [0:4] = '{16'hff0c, 16'hff14, 16'hff16, 16'hff18, 16'hff1a};
	localparam logic [15:0] CTRL_IDX      = 16'hff20;
	localparam logic [15:0] STAT_IDX      = 16'hff22;
	// Configuration word layout
	localparam int unsigned CYC_WAIT_LSB   = 0;
	localparam int unsigned CMD_DELAY_BIT  = 4;
	localparam int unsigned TRI_WAIT_BIT   = 5;
	localparam int unsigned BUS_TYPE_LSB   = 6;
	localparam int unsigned LATCH_LEN_BIT  = 9;
	localparam int unsigned REGION_ACT_BIT = 10;
	localparam int unsigned READY_EN_BIT   = 12;
	localparam int unsigned READY_POL_BIT  = 13;
	localparam int unsigned RD_GATE_BIT    = 14;
	localparam int unsigned WR_GATE_BIT    = 15;
	localparam logic [15:0] CFG_RW_MASK    = 16'hf6ff;
	localparam logic [15:0] CFG_RESET      = 16'h0000;
	localparam logic [15:0] STRAP_SET_MASK = 16'h0600;
	// Control register layout
	localparam int unsigned WR_PIN_CFG_BIT = 0;
	localparam int unsigned SEL_LATCH_BIT  = 1;
	localparam logic [15:0] CTRL_RW_MASK   = 16'h0003;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;

	typedef enum logic [1:0] {
		bt_demux8  = 2'h0,
		bt_mux8    = 2'h1,
		bt_demux16 = 2'h2,
		bt_mux16   = 2'h3
	} ebcc_bus_type;

	typedef enum logic [4:0] {
		st_idle  = 5'h01,
		st_addr  = 5'h02,
		st_delay = 5'h04,
		st_cmd   = 5'h08,
		st_tris  = 5'h10
	} ebcc_state_type;

	// Command phase length in cycles for a cycle wait field value
	function automatic logic [5:0] cmd_cycles(input logic [3:0] wait_field);
		return 6'(CMD_CYC + 6'(MAX_WAIT - wait_field) * WAIT_CYC);
	endfunction : cmd_cycles

	// Byte-lane merge of a 16-bit register write
	function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [1:0] lanes, input logic [15:0] mask);
		logic [15:0] m;
		m = {lanes[1] ? new_v[15:8] : old_v[15:8], lanes[0] ? new_v[7:0] : old_v[7:0]};
		return m & mask;
	endfunction : merge16
endpackage : ebcc_pkg

// ===== core/ebcc_sync.sv
// Two-stage synchroniser for pins entering the clock domain
`timescale 1ns/100ps
module ebcc_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i, // System clock
	input  wire logic [W-1:0] d_i,   // Asynchronous pin levels
	output logic      [W-1:0] q_o    // Synchronised levels
);
	logic [W-1:0] meta_r;

	// No reset, so strap pins stay valid across the reset pulse
	always_ff @(posedge clk_i) begin
		meta_r <= d_i;
		q_o    <= meta_r;
	end
endmodule : ebcc_sync

// ===== core/ebcc_region_sel.sv
// Region selection: picks the configuration word that governs an access
`timescale 1ns/100ps
module ebcc_region_sel (
	input  wire logic [4:0][15:0] cfg_i,     // Default word then window words
	input  wire logic [3:0]       win_hit_i, // Window hit flags from the decoder
	output logic      [2:0]       region_o,  // Chosen region, 0 is default
	output logic      [15:0]      cfg_o      // Chosen configuration word
);
	// Lowest window wins on overlap; no hit falls back to the default region
	assign region_o = win_hit_i[0] ? 3'h1 :
		win_hit_i[1] ? 3'h2 :
		win_hit_i[2] ? 3'h3 :
		win_hit_i[3] ? 3'h4 : 3'h0;
	assign cfg_o = cfg_i[region_o];
endmodule : ebcc_region_sel

// ===== core/ebcc_top.sv
// External bus cycle shaper with per-region configuration and Wishbone registers
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
module ebcc_top
	import ebcc_pkg::*;
(
	input  wire logic        clk_i,        // System clock
	input  wire logic        rst_i,        // Synchronous reset, active high
	input  wire logic [17:0] adr_i,        // Wishbone byte address
	input  wire logic [31:0] dat_i,        // Wishbone write data
	output logic      [31:0] dat_o,        // Wishbone read data
	input  wire logic [3:0]  sel_i,        // Wishbone byte selects
	input  wire logic        we_i,         // Wishbone write enable
	input  wire logic        cyc_i,        // Wishbone cycle
	input  wire logic        stb_i,        // Wishbone strobe
	output logic             ack_o,        // Wishbone acknowledge
	input  wire logic        acc_req_i,    // Access request pulse
	input  wire logic        acc_we_i,     // Access is a write
	input  wire logic [23:0] acc_addr_i,   // Access address
	input  wire logic [15:0] acc_wdata_i,  // Access write data
	input  wire logic [1:0]  acc_be_i,     // Access byte enables
	input  wire logic [3:0]  acc_win_i,    // Address window hits
	output logic             acc_done_o,   // Access finished pulse
	output logic             acc_skip_o,   // Access refused, region inactive
	output logic             acc_busy_o,   // Access in progress
	output logic      [15:0] acc_rdata_o,  // Read data
	input  wire logic        ext_access_i, // External access strap pin
	input  wire logic [1:0]  cfg_port_i,   // Config port bits 7 and 6
	input  wire logic        ready_i,      // Ready pin
	input  wire logic [15:0] ad_i,         // Data pins, input side
	output logic      [15:0] ad_o,         // Data pins, output side
	output logic             ad_oe_n_o,    // Data pin enable, low drives
	output logic      [23:0] addr_o,       // Address pins
	output logic             ale_o,        // Address latch strobe
	output logic             rd_n_o,       // Read strobe
	output logic             wr_n_o,       // Write or low-byte write strobe
	output logic             bhe_n_o,      // Byte-high enable or high-byte write strobe
	output logic      [4:0]  cs_n_o        // Chip selects, one per region
);
	ebcc_state_type  state_r, state_nxt;
	logic [5:0]      cnt_r, cnt_nxt;
	logic [4:0][15:0] cfg_pk;
	logic [15:0]     ctrl_r, cur_cfg_r, wdata_r, sel_cfg, rd_word;
	logic [23:0]     addr_r;
	logic [2:0]      region_r, sel_region;
	logic [1:0]      be_r, cap_r, port_s;
	logic [4:0]      cs_hold_r, cs_vec;
	logic [15:0]     ad_s;
	logic [6:0]      cmd_len_r;
	logic            we_r, init_r, rdy_s, ext_s, cmd_q_r;

	// Pins pass two flops before any logic reads them
	ebcc_sync #(.W(20)) u_sync (
		.clk_i (clk_i),
		.d_i   ({ready_i, ext_access_i, cfg_port_i, ad_i}),
		.q_o   ({rdy_s, ext_s, port_s, ad_s})
	);

	ebcc_region_sel u_sel (
		.cfg_i     (cfg_pk),
		.win_hit_i (acc_win_i),
		.region_o  (sel_region),
		.cfg_o     (sel_cfg)
	);

	// Wishbone decode
	wire        bus_hit  = cyc_i & stb_i & ~ack_o;
	wire        bus_wr   = cyc_i & stb_i & we_i & ack_o; // Lands at the acknowledge edge
	wire [15:0] word_adr = adr_i[17:2];
	wire        ctrl_hit = word_adr == CTRL_IDX;
	wire        stat_hit = word_adr == STAT_IDX;
	logic [4:0] cfg_hit;

	// Strap word caught just after reset release
	wire [15:0] strap_cfg = ext_s ? CFG_RESET :
		(CFG_RESET | STRAP_SET_MASK | (16'(port_s) << BUS_TYPE_LSB));

	// Configuration registers, one per region
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_cfg
			logic [15:0] word_r;
			assign cfg_hit[gi] = word_adr == CFG_IDX[gi];
			assign cfg_pk[gi]  = word_r;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					word_r <= CFG_RESET;
				end else if (gi == 0 && init_r) begin
					word_r <= strap_cfg;
				end else if (bus_wr && cfg_hit[gi]) begin
					word_r <= merge16(word_r, dat_i[15:0], sel_i[1:0], CFG_RW_MASK);
				end
			end
		end
	endgenerate

	// Control register and the one-shot strap load flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= CTRL_RESET;
			init_r <= 1'b1;
		end else begin
			init_r <= 1'b0;
			if (bus_wr && ctrl_hit) begin
				ctrl_r <= merge16(ctrl_r, dat_i[15:0], sel_i[1:0], CTRL_RW_MASK);
			end
		end
	end

	// Read mux; unmapped words read as zero and still acknowledge
	always_comb begin
		rd_word = 16'h0000;
		for (int i = 0; i < 5; i++) begin
			if (cfg_hit[i]) begin
				rd_word = cfg_pk[i];
			end
		end
		if (ctrl_hit) begin
			rd_word = ctrl_r;
		end
		if (stat_hit) begin
			rd_word = {7'h00, |cap_r, region_r, state_r};
		end
	end

	// Single-wait-state acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= bus_hit;
			dat_o <= bus_hit ? {16'h0000, rd_word} : 32'h0000_0000;
		end
	end

	// Fields of the configuration governing the running cycle
	ebcc_bus_type bus_type;
	assign bus_type = ebcc_bus_type'(cur_cfg_r[BUS_TYPE_LSB +: 2]);
	wire is_mux   = (bus_type == bt_mux8) || (bus_type == bt_mux16);
	wire is_16    = (bus_type == bt_demux16) || (bus_type == bt_mux16);
	wire rdy_mode = cur_cfg_r[READY_EN_BIT];
	wire rdy_hit  = rdy_s == cur_cfg_r[READY_POL_BIT];
	wire cnt_zero = cnt_r == 6'h00;
	wire cmd_end  = rdy_mode ? rdy_hit : cnt_zero;
	wire [5:0] cmd_load = cmd_cycles(cur_cfg_r[CYC_WAIT_LSB +: 4]) - 6'h01;
	wire idle_ok  = (state_r == st_idle) && (cap_r == 2'h0);
	wire take     = idle_ok && acc_req_i && sel_cfg[REGION_ACT_BIT];
	wire skip     = idle_ok && acc_req_i && !sel_cfg[REGION_ACT_BIT];
	wire in_cmd   = state_r == st_cmd;
	wire rd_end   = in_cmd && cmd_end && !we_r;
	wire finish   = (in_cmd && cmd_end && cur_cfg_r[TRI_WAIT_BIT]) ||
		(state_r == st_tris && cnt_zero);

	// Cycle sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_zero ? cnt_r : cnt_r - 6'h01;
		unique case (state_r)
			st_idle: begin
				if (take) begin
					state_nxt = st_addr;
					cnt_nxt   = (sel_cfg[LATCH_LEN_BIT] ? ALE_LONG_CYC : ALE_CYC) - 6'h01;
				end
			end
			st_addr: begin
				if (cnt_zero && cur_cfg_r[CMD_DELAY_BIT]) begin
					state_nxt = st_cmd;
					cnt_nxt   = cmd_load;
				end else if (cnt_zero) begin
					state_nxt = st_delay;
					cnt_nxt   = DELAY_CYC - 6'h01;
				end
			end
			st_delay: begin
				if (cnt_zero) begin
					state_nxt = st_cmd;
					cnt_nxt   = cmd_load;
				end
			end
			st_cmd: begin
				if (cmd_end) begin
					state_nxt = cur_cfg_r[TRI_WAIT_BIT] ? st_idle : st_tris;
					cnt_nxt   = WAIT_CYC - 6'h01;
				end
			end
			st_tris: begin
				if (cnt_zero) begin
					state_nxt = st_idle;
				end
			end
			default: begin
				state_nxt = st_idle;
			end
		endcase
	end

	// Sequencer state and the latched request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r   <= st_idle;
			cnt_r     <= 6'h00;
			cap_r     <= 2'h0;
			cur_cfg_r <= CFG_RESET;
			region_r  <= 3'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			cap_r   <= {cap_r[0], rd_end};
			if (take) begin
				cur_cfg_r <= sel_cfg;
				region_r  <= sel_region;
			end
		end
	end

	// Request fields are loaded on every take before any cycle uses them, so they need no reset
	always_ff @(posedge clk_i) begin
		if (take) begin
			we_r    <= acc_we_i;
			be_r    <= acc_be_i;
			addr_r  <= acc_addr_i;
			wdata_r <= acc_wdata_i;
		end
	end

	// Strobe and select terms from the current state
	wire in_cyc   = state_r != st_idle;
	wire rd_on    = in_cmd && !we_r;
	wire wr_on    = in_cmd && we_r;
	wire wr_split = ctrl_r[WR_PIN_CFG_BIT];
	wire wr_low   = wr_split ? (wr_on && be_r[0]) : wr_on;
	wire wr_high  = wr_split ? (wr_on && be_r[1]) : (in_cyc && is_16 && be_r[1]);
	wire rd_gated = cur_cfg_r[RD_GATE_BIT] && !we_r;
	wire wr_gated = cur_cfg_r[WR_GATE_BIT] && we_r;
	wire cs_live  = in_cyc && !(rd_gated && !rd_on) && !(wr_gated && !wr_on);
	wire cs_now   = ctrl_r[SEL_LATCH_BIT] || rd_gated || wr_gated;
	wire drv_addr = (state_r == st_addr) && is_mux;
	wire drv_data = we_r && (state_r == st_delay || in_cmd);
	assign cs_vec = cs_live ? 5'(5'h01 << region_r) : 5'h00;

	// Pin outputs, all straight from flops; gated selects bypass the latch stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ale_o     <= 1'b0;
			rd_n_o    <= 1'b1;
			wr_n_o    <= 1'b1;
			bhe_n_o   <= 1'b1;
			cs_hold_r <= 5'h00;
			cs_n_o    <= 5'h1f;
			addr_o    <= 24'h00_0000;
			ad_o      <= 16'h0000;
			ad_oe_n_o <= 1'b1;
			cmd_q_r   <= 1'b0;
		end else begin
			ale_o     <= state_r == st_addr;
			rd_n_o    <= !rd_on;
			wr_n_o    <= !wr_low;
			bhe_n_o   <= !wr_high;
			cs_hold_r <= cs_vec;
			cs_n_o    <= ~(cs_now ? cs_vec : cs_hold_r);
			addr_o    <= in_cyc ? addr_r : 24'h00_0000;
			ad_o      <= drv_addr ? addr_r[15:0] : wdata_r;
			ad_oe_n_o <= !(drv_addr || drv_data);
			cmd_q_r   <= in_cmd;
		end
	end

	// Access answer; read data lands two cycles after the strobe ends to cover the sync
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_done_o  <= 1'b0;
			acc_skip_o  <= 1'b0;
			acc_busy_o  <= 1'b0;
			acc_rdata_o <= 16'h0000;
		end else begin
			acc_done_o <= skip || (finish && we_r) || cap_r[1];
			acc_skip_o <= skip;
			acc_busy_o <= (state_nxt != st_idle) || rd_end || cap_r[0];
			if (cap_r[1]) begin
				acc_rdata_o <= is_16 ? ad_s : {8'h00, ad_s[7:0]};
			end
		end
	end

	// Command length counter used only by the checks below
	always_ff @(posedge clk_i) begin
		if (rst_i || !in_cmd) begin
			cmd_len_r <= 7'h00;
		end else begin
			cmd_len_r <= cmd_len_r + 7'h01;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence ale_fall_s;
		$fell(ale_o);
	endsequence
	sequence ale_rise_s;
		$rose(ale_o);
	endsequence

	wait_count_a: assert property (in_cmd && cmd_end && !rdy_mode |->
		cmd_len_r + 7'h01 == 7'(cmd_cycles(cur_cfg_r[CYC_WAIT_LSB +: 4])))
		else $error("command length differs from wait field");
	cmd_delay_a: assert property (ale_fall_s and !cur_cfg_r[CMD_DELAY_BIT]
		|-> !cmd_q_r ##1 cmd_q_r) else $error("delayed command misplaced");
	no_delay_a: assert property (ale_fall_s and cur_cfg_r[CMD_DELAY_BIT]
		|-> cmd_q_r) else $error("undelayed command late");
	tristate_a: assert property (in_cmd && cmd_end && !cur_cfg_r[TRI_WAIT_BIT]
		|=> (state_r == st_tris)[*2] ##1 state_r == st_idle)
		else $error("tristate wait wrong");
	latch_long_a: assert property (ale_rise_s and cur_cfg_r[LATCH_LEN_BIT]
		|-> ale_o[*2] ##1 !ale_o) else $error("lengthened strobe wrong");
	latch_norm_a: assert property (ale_rise_s and !cur_cfg_r[LATCH_LEN_BIT]
		|=> !ale_o) else $error("normal strobe wrong");
	region_off_a: assert property (skip |=> acc_skip_o && acc_done_o && !ale_o)
		else $error("inactive region used bus");
	ready_wait_a: assert property (in_cmd && rdy_mode && !rdy_hit |=> in_cmd)
		else $error("cycle ended without ready");
	ready_end_a: assert property (in_cmd && rdy_mode && rdy_hit |=> !in_cmd)
		else $error("ready did not end cycle");
	rd_gate_a: assert property (!(&cs_n_o) && rd_gated && !ctrl_r[SEL_LATCH_BIT]
		|-> !rd_n_o) else $error("select outside read strobe");
	wr_gate_a: assert property (!(&cs_n_o) && wr_gated |-> cmd_q_r)
		else $error("select outside write strobe");
	strap_load_a: assert property (init_r && !ext_s |=>
		cfg_pk[0][REGION_ACT_BIT] && cfg_pk[0][LATCH_LEN_BIT]) else $error("strap not loaded");
	wr_split_a: assert property (wr_split && !bhe_n_o |-> cmd_q_r)
		else $error("high byte strobe outside command");
	cs_latch_a: assert property (ale_rise_s and !cs_now |-> (&cs_n_o) ##1 !(&cs_n_o))
		else $error("latched select timing wrong");

	// Pin-level checks of the address phase and the write strobes
	bus_mux_a: assert property (ale_rise_s |-> ad_oe_n_o == !is_mux)
		else $error("address phase on data pins wrong");
	wr_plain_a: assert property (!wr_split && !wr_n_o |-> cmd_q_r)
		else $error("write strobe outside command");
	wr_data_a: assert property (!wr_n_o |-> !ad_oe_n_o && ad_o == wdata_r)
		else $error("write data not driven under strobe");
endmodule : ebcc_top

// ===== verification/ebcc_ext_mem.sv
// Partner model: external memory that answers reads and drives the ready pin
`timescale 1ns/100ps
module ebcc_ext_mem (
	input  wire logic        clk_i,   // System clock
	input  wire logic        rd_n_i,  // Read strobe, active low
	input  wire logic        wr_n_i,  // Write strobe, active low
	input  wire logic [23:0] addr_i,  // Address pins
	input  wire logic [7:0]  dly_i,   // Strobe cycles before ready goes active
	input  wire logic        pol_i,   // Active level of ready
	output logic      [15:0] ad_o,    // Data toward the block
	output logic             ready_o  // Ready pin
);
	logic [7:0]  cnt_r  = 8'h00;
	logic [15:0] last_r = 16'h0000;
	logic        stb;

	// Count strobe cycles and remember the last value put on the bus
	assign stb = !rd_n_i || !wr_n_i;
	always_ff @(posedge clk_i) begin
		cnt_r  <= stb ? cnt_r + 8'h01 : 8'h00;
		last_r <= ad_o;
	end
	// Released bus toggles every cycle so a stale value never passes as data
	assign ad_o    = !rd_n_i ? (addr_i[15:0] ^ 16'ha5c3) : ~last_r;
	// Ready is held inactive until the programmed delay has run
	assign ready_o = (stb && cnt_r >= dly_i) ? pol_i : ~pol_i;
endmodule : ebcc_ext_mem

// ===== verification/tb_ebcc_top.sv
// Testbench: register access over Wishbone and shaped external cycles
`timescale 1ns/100ps
module tb_ebcc_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        we_i, cyc_i, stb_i, acc_req_i, acc_we_i, ext_access_i, ack_o, acc_done_o;
	logic        acc_skip_o, acc_busy_o, ad_oe_n_o, ale_o, rd_n_o, wr_n_o, bhe_n_o, ready_i;
	logic        m_pol;
	logic [1:0]  cfg_port_i, acc_be_i;
	logic [3:0]  sel_i, acc_win_i;
	logic [4:0]  cs_n_o;
	logic [7:0]  m_dly;
	logic [15:0] acc_wdata_i, acc_rdata_o, ad_i, ad_o;
	logic [17:0] adr_i;
	logic [23:0] acc_addr_i, addr_o;
	logic [31:0] dat_i, dat_o, q;
	int          errors = 0;
	int          checked = 0;
	int          cycles = 0;
	// Per scenario: window hits and configuration word
	localparam logic [3:0]  TW [11] = '{4'h1, 4'h6, 4'h4, 4'h8, 4'h1, 4'h2, 4'h4, 4'h0, 4'h4, 4'h4,
		4'h2};
	localparam logic [15:0] TC [11] = '{16'h447e, 16'h86cd, 16'h048f, 16'h00ff, 16'h148f,
		16'h348f, 16'h0402, 16'h0680, 16'h048f, 16'h048f, 16'h0433};
	localparam logic [10:0] TWE = 11'h50a;

	ebcc_top uut (
		.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
		.sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
		.acc_req_i(acc_req_i), .acc_we_i(acc_we_i), .acc_addr_i(acc_addr_i),
		.acc_wdata_i(acc_wdata_i), .acc_be_i(acc_be_i), .acc_win_i(acc_win_i),
		.acc_done_o(acc_done_o), .acc_skip_o(acc_skip_o), .acc_busy_o(acc_busy_o),
		.acc_rdata_o(acc_rdata_o), .ext_access_i(ext_access_i), .cfg_port_i(cfg_port_i),
		.ready_i(ready_i), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_n_o(ad_oe_n_o), .addr_o(addr_o),
		.ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .bhe_n_o(bhe_n_o), .cs_n_o(cs_n_o)
	);
	ebcc_ext_mem mem (.clk_i(clk_i), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .addr_i(addr_o),
		.dly_i(m_dly), .pol_i(m_pol), .ad_o(ad_i), .ready_o(ready_i));

	// Clock and hang guard; ceiling well above the eleven shaped cycles plus registers
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			close_out();
		end
	end

	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task close_out;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// One classic Wishbone cycle; holds everything until ack is sampled
	task wb(input logic w, input logic [17:0] a, input logic [15:0] d, output logic [31:0] r);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= {16'h0000, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb

	function automatic logic [17:0] cadr(input int r);
		return (r == 0) ? 18'h3fc30 : 18'(18'h3fc48 + 8 * r);
	endfunction : cadr

	task do_reset(input logic ea, input logic [1:0] port);
		@(posedge clk_i);
		rst_i        <= 1'b1;
		ext_access_i <= ea;
		cfg_port_i   <= port;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : do_reset

	// Program a region, run one access and measure every phase of it
	task run(input int i);
		logic [15:0] c;
		logic [23:0] a;
		logic [1:0]  ctl;
		logic        s, mux, gate;
		int          r, n, ale0, ale1, stb0, cs0, nstb, nwr, nbhe, ncs, bad, cmd, nb;
		r = 0;
		for (int k = 3; k >= 0; k--)
			if (TW[i][k]) r = k + 1;
		c = TC[i];
		a = {20'h01234, i[3:0]};
		ctl = (i == 8) ? 2'b01 : (i == 9) ? 2'b10 : 2'b00;
		gate = TWE[i] ? c[15] : c[14];
		{n, ale0, ale1, stb0, cs0, nstb, nwr, nbhe, ncs, bad, nb, mux} = '0;
		wb(1'b1, 18'h3fc80, {14'h0000, ctl}, q);
		wb(1'b1, cadr(r), c, q);
		wb(1'b0, cadr(r), 16'h0000, q);
		chk(q, {16'h0000, c & ebcc_pkg::CFG_RW_MASK});
		m_dly       <= (i == 4 || i == 5) ? 8'h0c : 8'h00;
		m_pol       <= (i == 5);
		acc_req_i   <= 1'b1;
		acc_we_i    <= TWE[i];
		acc_addr_i  <= a;
		acc_wdata_i <= 16'h3c96;
		acc_be_i    <= ctl[0] ? 2'b10 : 2'b11;
		acc_win_i   <= TW[i];
		@(posedge clk_i);
		acc_req_i <= 1'b0;
		while (acc_done_o !== 1'b1 && n < 400) begin
			@(posedge clk_i);
			n++;
			s = !rd_n_o || !wr_n_o || (ctl[0] && !bhe_n_o);
			if (ale_o === 1'b1) begin
				if (ale0 == 0) ale0 = n;
				ale1 = n;
				if (!ad_oe_n_o && ad_o === a[15:0]) mux = 1'b1;
			end
			if (s && stb0 == 0) stb0 = n;
			if (s) nstb++;
			if (acc_busy_o === 1'b1) nb++;
			if (s && addr_o !== a) bad++;
			if (!wr_n_o) nwr++;
			if (!bhe_n_o) nbhe++;
			if (s && TWE[i] && c[7] && (ad_oe_n_o || ad_o !== 16'h3c96)) bad++;
			if ((cs_n_o | (5'h01 << r)) !== 5'h1f) bad++;
			if (!cs_n_o[r]) begin
				ncs++;
				if (cs0 == 0) cs0 = n;
				if (gate && !s) bad++;
			end
		end
		if (!c[10]) begin
			chk(acc_skip_o, 1'b1);
			chk(n + nstb, 1);
		end else begin
			cmd = c[12] ? nstb : 2 + 2 * (15 - c[3:0]);
			if (c[12]) chk(nstb > m_dly && nstb < m_dly + 8, 1'b1);
			else chk(nstb, cmd);
			chk(ale1 - ale0 + 1, c[9] ? 2 : 1);
			chk(stb0 - ale1 - 1, c[4] ? 0 : 1);
			chk(n, (c[9] ? 2 : 1) + (c[4] ? 0 : 1) + cmd + ((TWE[i] && c[5]) ? 0 : 2) + 1);
			chk(mux, c[6]);
			chk(bad, 0);
			if (gate) chk(ncs, nstb);
			else chk(cs0 - ale0, ctl[1] ? 0 : 1);
			if (!TWE[i]) chk(acc_rdata_o, c[7] ? a[15:0] ^ 16'ha5c3 : {8'h00, a[7:0] ^ 8'hc3});
			else if (ctl[0]) begin
				chk(nwr, 0);
				chk(nbhe, cmd);
			end else begin
				chk(nwr, cmd);
				chk(nbhe, c[7] ? n - 1 : 0);
			end
		end
		chk(nb, n - 1);
	endtask : run

	// Main sequence: straps, register map, then every shaped cycle
	initial begin
		{we_i, cyc_i, stb_i, acc_req_i, acc_we_i, ext_access_i, m_pol} = '0;
		{cfg_port_i, acc_be_i, acc_win_i, m_dly, acc_wdata_i, adr_i, acc_addr_i} = '0;
		cfg_port_i = 2'b11;
		sel_i = 4'h3;
		dat_i = 32'h00000000;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		wb(1'b0, 18'h3fc30, 16'h0000, q);
		chk(q, 32'h000006c0);
		for (int k = 1; k < 5; k++) begin
			wb(1'b0, cadr(k), 16'h0000, q);
			chk(q, 32'h00000000);
		end
		wb(1'b1, 18'h3fd00, 16'hffff, q);
		wb(1'b0, 18'h3fd00, 16'h0000, q);
		chk(q, 32'h00000000);
		sel_i <= 4'h1;
		wb(1'b1, cadr(1), 16'hffff, q);
		sel_i <= 4'h3;
		wb(1'b0, cadr(1), 16'h0000, q);
		chk(q, 32'h000000ff);
		wb(1'b1, cadr(2), 16'hffff, q);
		wb(1'b0, cadr(2), 16'h0000, q);
		chk(q, 32'h0000f6ff);
		do_reset(1'b1, 2'b10);
		wb(1'b0, cadr(2), 16'h0000, q);
		chk(q, 32'h00000000);
		wb(1'b0, 18'h3fc30, 16'h0000, q);
		chk(q, 32'h00000000);
		do_reset(1'b0, 2'b10);
		wb(1'b0, 18'h3fc30, 16'h0000, q);
		chk(q, 32'h00000680);
		for (int i = 0; i < 11; i++)
			run(i);
		wb(1'b0, 18'h3fc88, 16'h0000, q);
		chk(q, 32'h00000041);
		close_out();
	end
endmodule : tb_ebcc_top
